// ### src/nand_host_map.vh
// Functional notes
// - Bus value valid around write strobe rise
// - Command latch high stores command byte
// - Address latch high stores address byte
// - Power-on read pin enables auto read
// - Commands and addresses on low eight lines
// - Host sends four address cycles
`ifndef NAND_HOST_MAP_VH
`define NAND_HOST_MAP_VH

// =====================================================
// Pin timing in master clock cycles (20 MHz, 50 ns)
// =====================================================
`define CLK_PERIOD_NS       50
`define STROBE_LOW_NS       60
`define STROBE_HIGH_NS      60
`define STROBE_LOW_CYC      ((`STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_HIGH_CYC     ((`STROBE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_WAIT_NS        200
`define BUSY_WAIT_CYC       ((`BUSY_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_CYCLES         4

// =====================================================
// Request kinds
// =====================================================
`define KIND_CMD            2'h0
`define KIND_ADDR           2'h1
`define KIND_WDATA          2'h2
`define KIND_RDATA          2'h3

`endif

// ### src/nand_host_fifo.v
`timescale 1ns/1ns
module nand_host_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             i_mclk,
    input  wire             i_reset,
    input  wire             i_ce,
    input  wire [WIDTH-1:0] i_wdata,
    input  wire             i_wvalid,
    output wire             o_wready,
    output wire [WIDTH-1:0] o_rdata,
    output wire             o_rvalid,
    input  wire             i_rready
);
    // =================================================
    // Storage and pointers
    // =================================================
    reg [WIDTH-1:0] mem [0:DEPTH-1];   // Word store
    reg [AW-1:0]    wptr_reg;          // Write index
    reg [AW-1:0]    rptr_reg;          // Read index
    reg [AW:0]      count_reg;         // Fill level

    wire push = i_wvalid && o_wready;
    wire pop  = o_rvalid && i_rready;

    assign o_wready = (count_reg != DEPTH[AW:0]);
    assign o_rvalid = (count_reg != {(AW+1){1'b0}});
    assign o_rdata  = mem[rptr_reg];

    // Pointer and level update; frozen while clock enable low
    always @(posedge i_mclk) begin
        if (i_reset) begin
            wptr_reg  <= {AW{1'b0}};
            rptr_reg  <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else if (i_ce) begin
            if (push) begin
                mem[wptr_reg] <= i_wdata;
                wptr_reg      <= wptr_reg + 1'b1;
            end
            if (pop)
                rptr_reg <= rptr_reg + 1'b1;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end
endmodule

// ### src/nand_host_ctrl.v
`timescale 1ns/1ns
`include "nand_host_map.vh"
module nand_host_ctrl #(
    parameter WIDE      = 0,       // 1 for word-wide part
    parameter FIFO_DEP  = 4,
    parameter FIFO_AW   = 2
) (
    input  wire        i_mclk,
    input  wire        i_reset,
    input  wire        i_ce,
    // User request port
    input  wire        i_req_valid,
    output wire        o_req_ready,
    input  wire [1:0]  i_req_kind,
    input  wire [15:0] i_req_data,
    input  wire        i_wait_ready,
    // Read data out
    output wire        o_rd_valid,
    input  wire        i_rd_ready,
    output wire [15:0] o_rd_data,
    // Status
    output reg         o_busy,
    output reg         o_flash_ready,
    input  wire        i_wp_allow,
    input  wire        i_auto_read_en,
    // Flash pins
    output reg         o_cmd_latch,
    output reg         o_addr_latch,
    output reg         o_chip_sel_n,
    output reg         o_write_strobe_n,
    output reg         o_read_strobe_n,
    output reg         o_write_prot_n,
    output reg         o_power_read,
    output reg  [15:0] o_io,
    output reg         o_io_oe,
    input  wire [15:0] i_io,
    input  wire        i_ready_busy_n
);
    // =================================================
    // State machine, one-hot
    // =================================================
    // One state per write strobe phase; a read keeps its low and high phases in S_RLOW; the timer sets their length
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_WLOW = 5'h02;
    localparam [4:0] S_WHI  = 5'h04;
    localparam [4:0] S_RLOW = 5'h08;
    localparam [4:0] S_WAIT = 5'h10;

    reg [4:0]  state_reg;
    reg [4:0]  state_next;
    reg [3:0]  cnt_reg;                // Phase timer
    reg [15:0] io_sync1_reg;           // Pin synchroniser stage 1
    reg [15:0] io_sync2_reg;           // Pin synchroniser stage 2
    reg        rb_sync1_reg;
    reg        rb_sync2_reg;
    reg [1:0]  kind_reg;               // Kind of last write-strobe request; reads do not load it

    // Lane mask: commands, addresses, narrow data use low byte
    function [15:0] lane_mask;
        input [1:0] kind;
        begin
            if (kind == `KIND_CMD || kind == `KIND_ADDR || WIDE == 0)
                lane_mask = 16'h00ff;
            else
                lane_mask = 16'hffff;
        end
    endfunction

    // =================================================
    // Read FIFO; back-pressure stalls read strobes
    // =================================================
    wire fifo_wready;
    // Sample once: strobe rise plus both synchroniser stages
    wire rd_sample = (state_reg == S_RLOW) &&
                     (cnt_reg == `STROBE_LOW_CYC + 2);
    nand_host_fifo #(.WIDTH(16), .DEPTH(FIFO_DEP), .AW(FIFO_AW)) u_fifo (
        .i_mclk   (i_mclk),
        .i_reset  (i_reset),
        .i_ce     (i_ce),
        .i_wdata  (io_sync2_reg & lane_mask(`KIND_RDATA)),
        .i_wvalid (rd_sample),
        .o_wready (fifo_wready),
        .o_rdata  (o_rd_data),
        .o_rvalid (o_rd_valid),
        .i_rready (i_rd_ready)
    );

    // Only accept a read when the FIFO has room for its word
    assign o_req_ready = (state_reg == S_IDLE) &&
                         (i_req_kind != `KIND_RDATA || fifo_wready);

    // =================================================
    // Pin synchronisers
    // =================================================
    // Two flops per pin; only stage two feeds any logic
    // Hazard: the bus is sampled as a word, so the device must
    // hold its data steady well past the read strobe rise
    always @(posedge i_mclk) begin
        if (i_reset) begin
            io_sync1_reg <= 16'h0000;
            io_sync2_reg <= 16'h0000;
            rb_sync1_reg <= 1'b0;
            rb_sync2_reg <= 1'b0;
        end else if (i_ce) begin
            io_sync1_reg <= i_io;
            io_sync2_reg <= io_sync1_reg;
            rb_sync1_reg <= i_ready_busy_n;
            rb_sync2_reg <= rb_sync1_reg;
        end
    end

    // =================================================
    // Next-state logic
    // =================================================
    // Phase sequencing; the timer restarts on every change
    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                // Take one request; a read also needs FIFO room
                if (i_req_valid && o_req_ready) begin
                    if (i_req_kind == `KIND_RDATA)
                        state_next = S_RLOW;
                    else
                        state_next = S_WLOW;
                end
            end
            S_WLOW: begin
                if (cnt_reg == `STROBE_LOW_CYC - 1)
                    state_next = S_WHI;
            end
            S_WHI: begin
                // Hold data past the rising edge before next change
                if (cnt_reg == `STROBE_HIGH_CYC - 1)
                    state_next = i_wait_ready ? S_WAIT : S_IDLE;
            end
            S_RLOW: begin
                // Low time plus synchroniser latency of the pins
                if (cnt_reg == `STROBE_LOW_CYC + 2)
                    state_next = S_IDLE;
            end
            S_WAIT: begin
                // Busy-line settle time, then wait for release
                if (cnt_reg >= `BUSY_WAIT_CYC && rb_sync2_reg)
                    state_next = S_IDLE;
            end
            default: state_next = S_IDLE;
        endcase
    end

    // =================================================
    // State, timer and pin drive
    // =================================================
    // Pins come straight from flops so strobes never glitch
    // Limitation: chip select is only raised in the busy wait;
    // a read burst keeps the part selected throughout
    always @(posedge i_mclk) begin
        if (i_reset) begin
            state_reg        <= S_IDLE;
            cnt_reg          <= 4'h0;
            kind_reg         <= `KIND_CMD;
            o_cmd_latch      <= 1'b0;
            o_addr_latch     <= 1'b0;
            o_chip_sel_n     <= 1'b1;
            o_write_strobe_n <= 1'b1;
            o_read_strobe_n  <= 1'b1;
            o_write_prot_n   <= 1'b0;     // Protected until enabled
            o_power_read     <= 1'b0;
            o_io             <= 16'h0000;
            o_io_oe          <= 1'b0;
            o_busy           <= 1'b0;
            o_flash_ready    <= 1'b0;
        end else if (i_ce) begin
            state_reg <= state_next;
            // Timer saturates so a long busy wait cannot wrap it
            if (state_next != state_reg)
                cnt_reg <= 4'h0;
            else if (cnt_reg != 4'hf)
                cnt_reg <= cnt_reg + 4'h1;
            o_write_prot_n <= i_wp_allow;
            o_power_read   <= i_auto_read_en;
            o_flash_ready  <= rb_sync2_reg;
            o_busy         <= (state_next != S_IDLE);
            case (state_next)
                S_WLOW: begin
                    if (state_reg == S_IDLE) begin
                        kind_reg     <= i_req_kind;
                        o_cmd_latch  <= (i_req_kind == `KIND_CMD);
                        o_addr_latch <= (i_req_kind == `KIND_ADDR);
                        o_io         <= i_req_data & lane_mask(i_req_kind);
                        o_io_oe      <= 1'b1;
                    end
                    o_chip_sel_n     <= 1'b0;
                    o_write_strobe_n <= 1'b0;
                end
                S_WHI: begin
                    // Rising strobe with data still stable
                    o_write_strobe_n <= 1'b1;
                end
                S_RLOW: begin
                    // Device drives bus; release ours first
                    o_io_oe         <= 1'b0;
                    o_chip_sel_n    <= 1'b0;
                    o_read_strobe_n <= (cnt_reg >= `STROBE_LOW_CYC - 1) &&
                                       (state_reg == S_RLOW);
                end
                S_WAIT: begin
                    // Deselect while busy; operation continues
                    o_io_oe      <= 1'b0;
                    o_cmd_latch  <= 1'b0;
                    o_addr_latch <= 1'b0;
                    o_chip_sel_n <= 1'b1;
                end
                default: begin
                    o_io_oe          <= 1'b0;
                    o_cmd_latch      <= 1'b0;
                    o_addr_latch     <= 1'b0;
                    o_write_strobe_n <= 1'b1;
                    o_read_strobe_n  <= 1'b1;
                end
            endcase
        end
    end
endmodule

// ### tb/nand_host_ctrl_asserts.sv
`timescale 1ns/1ns
// ==============================================
// Pin protocol checks on the host controller
// ==============================================
module nand_host_ctrl_chk #(
    parameter WIDE = 0
) (
    input logic        i_mclk,
    input logic        i_reset,
    input logic        i_ce,
    input logic        i_req_valid,
    input logic        o_req_ready,
    input logic [1:0]  i_req_kind,
    input logic [15:0] i_req_data,
    input logic        i_wp_allow,
    input logic        o_write_prot_n,
    input logic        o_cmd_latch,
    input logic        o_addr_latch,
    input logic        o_chip_sel_n,
    input logic        o_write_strobe_n,
    input logic        o_read_strobe_n,
    input logic [15:0] o_io,
    input logic        o_io_oe,
    input logic        o_busy
);
    logic tk; // Request taken at this edge
    assign tk = i_req_valid & o_req_ready & i_ce;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    // Strobe low for two cycles, then back high
    sequence s_strobe;
        !o_write_strobe_n [*2] ##1 o_write_strobe_n;
    endsequence
    property p_wr;
        tk && i_req_kind != 2'h3 |=> !o_chip_sel_n ##0 s_strobe;
    endproperty
    a_wr: assert property (p_wr) else $error("write strobe");
    property p_cmd;
        tk && i_req_kind == 2'h0 |=> o_cmd_latch && !o_addr_latch
            && o_io_oe && o_io[7:0] == $past(i_req_data[7:0]);
    endproperty
    a_cmd: assert property (p_cmd) else $error("command cycle");
    property p_addr;
        tk && i_req_kind == 2'h1 |=> o_addr_latch && !o_cmd_latch
            && o_io_oe && o_io[7:0] == $past(i_req_data[7:0]);
    endproperty
    a_addr: assert property (p_addr) else $error("address cycle");
    // Bus must hold across the latching rise
    property p_hold;
        $fell(o_write_strobe_n) |=> $stable(o_io) [*3];
    endproperty
    a_hold: assert property (p_hold) else $error("io moved");
    property p_rd;
        tk && i_req_kind == 2'h3 |=> !o_read_strobe_n && !o_io_oe
            ##1 !o_read_strobe_n ##1 o_read_strobe_n;
    endproperty
    a_rd: assert property (p_rd) else $error("read strobe");
    property p_wp;
        !$past(i_reset) && $past(i_ce) |-> o_write_prot_n == $past(i_wp_allow);
    endproperty
    a_wp: assert property (p_wp) else $error("write protect");
    property p_hi;
        WIDE == 0 && tk && i_req_kind != 2'h3 |=> o_io[15:8] == 8'h00;
    endproperty
    a_hi: assert property (p_hi) else $error("upper lanes");
    property p_busy;
        tk |=> o_busy && !o_req_ready;
    endproperty
    a_busy: assert property (p_busy) else $error("busy flag");
endmodule
bind nand_host_ctrl nand_host_ctrl_chk #(.WIDE(WIDE)) chk_inst (.*);

// ### tb/nand_dev_model.sv
`timescale 1ns/1ns
// ==============================================
// Behavioural flash device, one small page
// ==============================================
module nand_dev_model #(
    parameter BUSY_NS = 2000 // Shortened array time
) (
    input  wire        cle,
    input  wire        ale,
    input  wire        ce_n,
    input  wire        we_n,
    input  wire        re_n,
    input  wire        wp_n,
    input  wire [15:0] io_in,
    output reg  [15:0] io_out,
    output reg         io_en,
    output reg         busy_low
);
    reg [15:0] cache [0:15]; // Host data lands here first
    reg [15:0] mem   [0:15]; // Array page
    reg [3:0]  col;
    reg [2:0]  acnt;
    integer    k;
    event      go;
    initial begin
        io_out = 16'h0000;
        io_en = 1'b0;
        busy_low = 1'b0;
        col = 4'h0;
        acnt = 3'h0;
        for (k = 0; k < 16; k = k + 1) begin
            mem[k] = 16'hffff;
            cache[k] = 16'hffff;
        end
    end
    // Latch on the write strobe rise only
    always @(posedge we_n) if (!ce_n) begin
        if (cle) begin
            acnt = 3'h0;
            // Program and cache program: cache moves to the array and
            // is free at once for the next page of data
            if ((io_in[7:0] == 8'h10 || io_in[7:0] == 8'h15) && wp_n) begin
                for (k = 0; k < 16; k = k + 1) mem[k] = cache[k];
                -> go;
            end
            // Copy-back read: page reloaded for an internal reprogram
            if (io_in[7:0] == 8'h35) begin
                for (k = 0; k < 16; k = k + 1) cache[k] = mem[k];
                -> go;
            end
            if (io_in[7:0] == 8'h30 || io_in[7:0] == 8'h31) -> go;
        end else if (ale) begin
            if (acnt == 3'h0) col = io_in[3:0];
            acnt = acnt + 3'h1;
        end else begin
            cache[col] = io_in;
            col = col + 4'h1;
        end
    end
    // Open-drain busy, no abort by chip select
    always @(go) begin
        busy_low = 1'b1;
        #BUSY_NS busy_low = 1'b0;
    end
    always @(negedge re_n) if (!ce_n) begin
        io_out = mem[col];
        io_en = 1'b1;
        col = col + 4'h1;
    end
    // Bus floats on a write cycle and whenever deselected
    always @(negedge we_n or posedge ce_n) io_en = 1'b0;
endmodule

// ### tb/nand_host_ctrl_tb.sv
`timescale 1ns/1ns
module nand_host_ctrl_tb;
    // ==============================================
    // Stimulus, pins and counters
    // ==============================================
    reg         i_mclk = 0, i_reset = 1, i_ce = 1, i_req_valid = 0;
    reg         i_wait_ready = 0, i_rd_ready = 0, i_wp_allow = 1;
    reg         i_auto_read_en = 0;
    reg  [1:0]  i_req_kind = 0;
    reg  [15:0] i_req_data = 0;
    wire        o_req_ready, o_rd_valid, o_busy, o_flash_ready, o_io_oe;
    wire        o_cmd_latch, o_addr_latch, o_chip_sel_n, o_power_read;
    wire        o_write_strobe_n, o_read_strobe_n, o_write_prot_n;
    wire [15:0] o_rd_data, o_io, i_io, dev_io;
    wire        dev_en, dev_busy, i_ready_busy_n;
    integer     miscompares = 0, n_tests = 0, cyc = 0, k;
    reg  [15:0] pat [0:3];
    // Released bus shows the inverse, not a stale value
    // Upper lanes of the x8 part float: shown inverted so masking shows
    assign i_io = o_io_oe ? o_io :
                  {~dev_io[15:8], dev_en ? dev_io[7:0] : ~dev_io[7:0]};
    assign i_ready_busy_n = !dev_busy;
    always #25 i_mclk = ~i_mclk;
    nand_host_ctrl #(.WIDE(0)) nand_host_ctrl_inst (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce),
        .i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
        .i_req_kind(i_req_kind), .i_req_data(i_req_data),
        .i_wait_ready(i_wait_ready), .o_rd_valid(o_rd_valid),
        .i_rd_ready(i_rd_ready), .o_rd_data(o_rd_data), .o_busy(o_busy),
        .o_flash_ready(o_flash_ready), .i_wp_allow(i_wp_allow),
        .i_auto_read_en(i_auto_read_en), .o_cmd_latch(o_cmd_latch),
        .o_addr_latch(o_addr_latch), .o_chip_sel_n(o_chip_sel_n),
        .o_write_strobe_n(o_write_strobe_n),
        .o_read_strobe_n(o_read_strobe_n),
        .o_write_prot_n(o_write_prot_n), .o_power_read(o_power_read),
        .o_io(o_io), .o_io_oe(o_io_oe), .i_io(i_io),
        .i_ready_busy_n(i_ready_busy_n));
    nand_dev_model nand_dev_model_inst (.cle(o_cmd_latch),
        .ale(o_addr_latch), .ce_n(o_chip_sel_n), .we_n(o_write_strobe_n),
        .re_n(o_read_strobe_n), .wp_n(o_write_prot_n), .io_in(i_io),
        .io_out(dev_io), .io_en(dev_en), .busy_low(dev_busy));
    // ==============================================
    // Shared tasks
    // ==============================================
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task req(input [1:0] kd, input [15:0] d, input w);
        begin
            @(posedge i_mclk);
            i_req_valid <= 1;
            i_req_kind <= kd;
            i_req_data <= d;
            i_wait_ready <= w;
            @(negedge i_mclk);
            while (!o_req_ready) @(negedge i_mclk);
            @(posedge i_mclk);
            i_req_valid <= 0;
            @(negedge i_mclk);
            while (o_busy) @(negedge i_mclk);
        end
    endtask
    task addr4;
        begin
            for (k = 0; k < 4; k = k + 1) req(2'h1, 16'h0000, 0);
        end
    endtask
    task pop(input [15:0] e);
        begin
            @(negedge i_mclk);
            while (!o_rd_valid) @(negedge i_mclk);
            chk(o_rd_data, e);
            @(posedge i_mclk) i_rd_ready <= 1;
            @(posedge i_mclk) i_rd_ready <= 0;
        end
    endtask
    // ==============================================
    // Scenarios
    // ==============================================
    // Program start is not waited on, so the busy line is seen itself
    task t_program(input [15:0] x, input ok);
        begin
            req(2'h0, 16'h0080, 0);
            addr4;
            for (k = 0; k < 4; k = k + 1) req(2'h2, pat[k] ^ x, 0);
            req(2'h0, 16'h0010, 0);
            repeat (4) @(negedge i_mclk);
            chk({15'h0, o_flash_ready}, {15'h0, !ok});
            while (!o_flash_ready) @(negedge i_mclk);
        end
    endtask
    // Clock enable low must freeze the registered pins
    task t_freeze;
        begin
            @(posedge i_mclk);
            i_ce <= 0;
            i_wp_allow <= 0;
            repeat (3) @(negedge i_mclk);
            chk({15'h0, o_write_prot_n}, 16'h0001);
            @(posedge i_mclk) i_ce <= 1;
            repeat (2) @(negedge i_mclk);
            chk({15'h0, o_write_prot_n}, 16'h0000);
            @(posedge i_mclk) i_wp_allow <= 1;
        end
    endtask
    // Fill the FIFO, see it refuse, then drain
    task t_read;
        begin
            req(2'h0, 16'h0000, 0);
            addr4;
            req(2'h0, 16'h0030, 1);
            for (k = 0; k < 4; k = k + 1) req(2'h3, 16'h0000, 0);
            @(posedge i_mclk) i_req_valid <= 1;
            @(negedge i_mclk) chk({15'h0, o_req_ready}, 16'h0000);
            @(posedge i_mclk) i_req_valid <= 0;
            for (k = 0; k < 4; k = k + 1) pop(pat[k] & 16'h00ff);
        end
    endtask
    task t_protect;
        begin
            @(posedge i_mclk);
            i_wp_allow <= 0;
            i_auto_read_en <= 1;
            repeat (2) @(negedge i_mclk);
            chk({15'h0, o_write_prot_n}, 16'h0000);
            chk({15'h0, o_power_read}, 16'h0001);
            t_program(16'h00ff, 0);
            @(posedge i_mclk) i_wp_allow <= 1;
            t_read;
        end
    endtask
    task results;
        begin
            $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
            if (miscompares == 0 && n_tests > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // Hang guard, far above the expected run
    always @(posedge i_mclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            miscompares = miscompares + 1;
            results;
        end
    end
    initial begin
        pat[0] = 16'ha55a;
        pat[1] = 16'h3cc3;
        pat[2] = 16'h0f11;
        pat[3] = 16'h77f0;
        repeat (3) @(posedge i_mclk);
        i_reset <= 0;
        t_program(16'h0000, 1);
        t_read;
        t_freeze;
        t_protect;
        results;
    end
endmodule
